// ===== strap_cfg_pkg.sv
// strap_cfg_pkg: constants and carriers for the strap configuration block.
// assumes a single 100 MHz clock domain and synchronous active-high reset.
package strap_cfg_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int BAUD_DIV = CLK_HZ / BAUD_RATE;
    localparam int CHAR_BITS = 7;
    localparam int STOP_BITS = 1;
    localparam int FRAME_BITS = 1 + CHAR_BITS + STOP_BITS;

    // ****************************************
    // host address map (22-bit bus byte addresses)
    // ****************************************
    localparam int HADDR_W = 22;
    localparam int NUM_BASE_SEL = 6;
    localparam logic [HADDR_W-1:0] BASE_ADDR_0 = 22'o17772150;
    localparam logic [HADDR_W-1:0] BASE_ADDR_1 = 22'o17760334;
    localparam logic [HADDR_W-1:0] BASE_ADDR_2 = 22'o17760354;
    localparam logic [HADDR_W-1:0] BASE_ADDR_3 = 22'o17760374;
    localparam logic [HADDR_W-1:0] BASE_ADDR_4 = 22'o17760414;
    localparam logic [HADDR_W-1:0] BASE_ADDR_5 = 22'o17760434;
    localparam logic [31:0] BASE_ADDR32_0 = 32'h20001468;
    localparam logic [31:0] BASE_ADDR32_1 = 32'h200000DC;
    localparam logic [31:0] BASE_ADDR32_2 = 32'h200000EC;
    localparam logic [31:0] BASE_ADDR32_3 = 32'h200000FC;
    localparam logic [31:0] BASE_ADDR32_4 = 32'h2000010C;
    localparam logic [31:0] BASE_ADDR32_5 = 32'h2000011C;
    localparam logic [HADDR_W-1:0] CSR_SPAN = 22'h000004;
    localparam logic [HADDR_W-1:0] BOOT_HIGH_BASE = 22'o17773000;
    localparam logic [HADDR_W-1:0] BOOT_LOW_BASE = 22'o17771000;
    localparam logic [HADDR_W-1:0] BOOT_SPAN = 22'h000200;
    localparam int BOOT_AW = 8;

    // ****************************************
    // interrupt level codes
    // ****************************************
    localparam logic [2:0] PRI_CODE_4 = 3'h0;
    localparam logic [2:0] PRI_CODE_5 = 3'h1;
    localparam logic [2:0] PRI_CODE_6 = 3'h2;
    localparam logic [2:0] PRI_CODE_7 = 3'h6;
    localparam logic [2:0] IRQ_LEVEL_4 = 3'h4;
    localparam logic [2:0] IRQ_LEVEL_5 = 3'h5;
    localparam logic [2:0] IRQ_LEVEL_6 = 3'h6;
    localparam logic [2:0] IRQ_LEVEL_7 = 3'h7;

    // ****************************************
    // drives, queue, cache
    // ****************************************
    localparam int NUM_DRIVES = 2;
    localparam int QUEUE_DEPTH = 32;
    localparam int CACHE_AW = 20;
    localparam int CACHE_DW = 8;

    // ****************************************
    // register map (word index * 4)
    // ****************************************
    localparam int RAW = 8;
    localparam logic [RAW-1:0] REG_CONFIG = 8'h00;
    localparam logic [RAW-1:0] REG_STATUS = 8'h04;
    localparam logic [RAW-1:0] REG_IRQ_STAT = 8'h08;
    localparam logic [RAW-1:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [RAW-1:0] REG_CONTROL = 8'h10;
    localparam logic [RAW-1:0] REG_QUEUE = 8'h14;
    localparam logic [RAW-1:0] REG_UART_TX = 8'h18;
    localparam logic [RAW-1:0] REG_UART_RX = 8'h1C;

    // interrupt status bits
    localparam int EV_FATAL = 0;
    localparam int EV_PARITY = 1;
    localparam int EV_RX = 2;
    localparam int EV_QFULL = 3;
    localparam int EV_WP_VIOL = 4;
    localparam int NUM_EV = 5;

    // control bits
    localparam int CTL_FATAL = 0;
    localparam int CTL_ACTIVE = 1;
    localparam int CTL_POP = 2;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [NUM_BASE_SEL-1:0] base_sel;
        logic boot_rom_off_sel;
        logic boot_rom_high_window_sel;
        logic boot_rom_low_window_sel;
        logic irq_level_bit2;
        logic irq_level_bit1;
        logic irq_level_bit0;
        logic drive1_removable_flag;
        logic drive0_removable_flag;
        logic powerup_utility_sel;
    } strap_t;

    typedef struct packed {
        logic [HADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } host_req_t;

    typedef struct packed {
        logic [HADDR_W-1:0] addr;
        logic wr;
        logic req;
    } dma_req_t;

    typedef enum logic [2:0] {
        PU_RESET = 3'b001,
        PU_NORMAL = 3'b010,
        PU_UTILITY = 3'b100
    } pu_state_t;

endpackage : strap_cfg_pkg

// ===== serial_tx7.sv
// serial_tx7: 7-data-bit, 1-stop-bit, no-parity serial transmitter.
// assumes the caller holds data stable on the cycle start is high.
`timescale 1ns/1ps
module serial_tx7 #(
    parameter int DIV = strap_cfg_pkg::BAUD_DIV,
    parameter int DW = strap_cfg_pkg::CHAR_BITS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // character in
    input wire logic start,
    input wire logic [DW-1:0] data,
    output logic busy,
    // line
    output logic txd
);
    import strap_cfg_pkg::*;

    logic [DW+1:0] shift_reg;
    logic [15:0] tick_reg;
    logic [3:0] bits_reg;
    wire tick_done = (tick_reg == 16'(DIV - 1));

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shift_reg <= '1;
            tick_reg <= 16'h0000;
            bits_reg <= 4'h0;
            busy <= 1'b0;
            txd <= 1'b1;
        end else if (!busy) begin
            txd <= 1'b1;
            if (start) begin
                // start bit low, data lsb first, stop bit high
                shift_reg <= {1'b1, data, 1'b0};
                bits_reg <= 4'(FRAME_BITS);
                tick_reg <= 16'h0000;
                busy <= 1'b1;
            end
        end else begin
            txd <= shift_reg[0];
            tick_reg <= tick_done ? 16'h0000 : tick_reg + 16'h0001;
            if (tick_done) begin
                shift_reg <= {1'b1, shift_reg[DW+1:1]};
                bits_reg <= bits_reg - 4'h1;
                busy <= (bits_reg != 4'h1);
            end
        end
    end
endmodule : serial_tx7

// ===== disc_controller_strap_config.sv
// disc_controller_strap_config: plug decode, host windows, irq level,
// drive gating, command queue, parity cache, maintenance serial port.
// assumes static plugs in reset; inputs synchronous to ref_clk.
//
// Functional notes
// - base register address chosen by six one-hot address plugs
// - first boot plug set: never answer any boot rom window
// - second boot plug set: boot rom answers at 17773000
// - third boot plug set: boot rom answers at 17771000
// - priority plugs 000/001/010/110 give interrupt levels 4/5/6/7
// - each drive's media plug 1 means removable, 0 fixed
// - mode plug 1 starts utility at power-up, 0 normal power-up
// - serial port runs 9600 baud, 7 data bits, 1 stop, no parity
// - dma drives 22-bit host memory addresses in block mode
// - up to 32 outstanding host commands held at once
// - write-protect and online inputs per drive govern writes and use
// - red lamp on fatal error, green lamp while access in progress
// - parity-protected cache, parity checked on every read
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module disc_controller_strap_config #(
    parameter int QDEPTH = strap_cfg_pkg::QUEUE_DEPTH,
    parameter int CAW = strap_cfg_pkg::CACHE_AW,
    parameter int BAUD_CYC = strap_cfg_pkg::BAUD_DIV
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // configuration plugs
    input wire strap_cfg_pkg::strap_t straps,
    // register port
    input wire logic [strap_cfg_pkg::RAW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // host bus slave
    input wire strap_cfg_pkg::host_req_t host_req,
    output logic [15:0] host_rdata,
    output logic host_ack,
    output logic [2:0] host_irq_level,
    // dma master
    input wire logic [strap_cfg_pkg::HADDR_W-1:0] dma_addr_in,
    input wire logic dma_start,
    input wire logic dma_write,
    output strap_cfg_pkg::dma_req_t dma_out,
    // drives
    input wire logic [strap_cfg_pkg::NUM_DRIVES-1:0] drive_wprot,
    input wire logic [strap_cfg_pkg::NUM_DRIVES-1:0] drive_online,
    input wire logic [strap_cfg_pkg::NUM_DRIVES-1:0] drive_wr_req,
    output logic [strap_cfg_pkg::NUM_DRIVES-1:0] drive_wr_gate,
    output logic [strap_cfg_pkg::NUM_DRIVES-1:0] drive_removable,
    // cache
    input wire logic cache_wr,
    input wire logic cache_rd,
    input wire logic [strap_cfg_pkg::CACHE_AW-1:0] cache_addr,
    input wire logic [strap_cfg_pkg::CACHE_DW-1:0] cache_wdata,
    output logic [strap_cfg_pkg::CACHE_DW-1:0] cache_rdata,
    output logic cache_parity_err,
    // indicators and mode
    output logic led_red,
    output logic led_green,
    output logic utility_mode,
    // maintenance serial
    input wire logic maint_rxd,
    output logic maint_txd
);
    import strap_cfg_pkg::*;

    // ****************************************
    // strap capture
    // ****************************************
    strap_t strap_reg;
    pu_state_t pu_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            strap_reg <= straps;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pu_reg <= PU_RESET;
        end else begin
            case (pu_reg)
                PU_RESET: pu_reg <= strap_reg.powerup_utility_sel ? PU_UTILITY : PU_NORMAL;
                PU_NORMAL: pu_reg <= PU_NORMAL;
                PU_UTILITY: pu_reg <= PU_UTILITY;
                default: pu_reg <= PU_RESET;
            endcase
        end
    end

    // ****************************************
    // address decode
    // ****************************************
    // one-hot base select, lowest plug wins if several are set
    wire [HADDR_W-1:0] base_addr =
        strap_reg.base_sel[0] ? BASE_ADDR_0 :
        strap_reg.base_sel[1] ? BASE_ADDR_1 :
        strap_reg.base_sel[2] ? BASE_ADDR_2 :
        strap_reg.base_sel[3] ? BASE_ADDR_3 :
        strap_reg.base_sel[4] ? BASE_ADDR_4 : BASE_ADDR_5;
    wire [31:0] base_addr32 =
        strap_reg.base_sel[0] ? BASE_ADDR32_0 :
        strap_reg.base_sel[1] ? BASE_ADDR32_1 :
        strap_reg.base_sel[2] ? BASE_ADDR32_2 :
        strap_reg.base_sel[3] ? BASE_ADDR32_3 :
        strap_reg.base_sel[4] ? BASE_ADDR32_4 : BASE_ADDR32_5;
    wire base_valid = |strap_reg.base_sel;
    wire host_cyc = host_req.wr | host_req.rd;
    wire csr_hit = base_valid && host_req.addr >= base_addr
        && host_req.addr < base_addr + CSR_SPAN;
    wire boot_on = !strap_reg.boot_rom_off_sel;
    wire boot_hi_hit = boot_on && strap_reg.boot_rom_high_window_sel
        && host_req.addr >= BOOT_HIGH_BASE && host_req.addr < BOOT_HIGH_BASE + BOOT_SPAN;
    wire boot_lo_hit = boot_on && !strap_reg.boot_rom_high_window_sel
        && strap_reg.boot_rom_low_window_sel
        && host_req.addr >= BOOT_LOW_BASE && host_req.addr < BOOT_LOW_BASE + BOOT_SPAN;
    wire boot_hit = (boot_hi_hit | boot_lo_hit) & host_req.rd;
    wire [BOOT_AW-1:0] boot_idx = host_req.addr[BOOT_AW:1];

    // rom image left zero here
    logic [15:0] boot_rom [0:(1<<BOOT_AW)-1];
    initial begin
        for (int i = 0; i < (1 << BOOT_AW); i++) begin
            boot_rom[i] = 16'h0000;
        end
    end

    wire [2:0] pri_code = {strap_reg.irq_level_bit2, strap_reg.irq_level_bit1,
        strap_reg.irq_level_bit0};
    wire [2:0] level_next =
        (pri_code == PRI_CODE_7) ? IRQ_LEVEL_7 :
        (pri_code == PRI_CODE_6) ? IRQ_LEVEL_6 :
        (pri_code == PRI_CODE_5) ? IRQ_LEVEL_5 : IRQ_LEVEL_4;

    // ****************************************
    // command queue
    // ****************************************
    localparam int QCW = $clog2(QDEPTH + 1);
    logic [QCW-1:0] q_count_reg;
    logic [15:0] q_mem [0:QDEPTH-1];
    logic [QCW-2:0] q_wp_reg;
    logic [QCW-2:0] q_rp_reg;
    wire q_full = (q_count_reg == QCW'(QDEPTH));
    wire q_empty = (q_count_reg == '0);
    wire reg_pop = reg_wr && reg_addr == REG_CONTROL && reg_wdata[CTL_POP];
    // commands are host writes to the csr word
    wire q_push = csr_hit && host_req.wr && !q_full;
    wire q_pop = reg_pop && !q_empty;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q_count_reg <= '0;
            q_wp_reg <= '0;
            q_rp_reg <= '0;
        end else begin
            if (q_push) begin
                q_wp_reg <= q_wp_reg + 1'b1;
            end
            if (q_pop) begin
                q_rp_reg <= q_rp_reg + 1'b1;
            end
            q_count_reg <= q_count_reg + QCW'(q_push) - QCW'(q_pop);
        end
    end
    always_ff @(posedge ref_clk) begin
        if (q_push) begin
            q_mem[q_wp_reg] <= host_req.wdata;
        end
    end

    // ****************************************
    // host bus answers
    // ****************************************
    wire [15:0] host_csr_data = {11'h000, q_count_reg[4:0] == 5'h00 && q_full ? 5'h1F
        : q_count_reg[4:0]};
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_ack <= 1'b0;
            host_rdata <= 16'h0000;
            host_irq_level <= IRQ_LEVEL_4;
        end else begin
            host_ack <= host_cyc && (csr_hit || boot_hit);
            host_rdata <= boot_hit ? boot_rom[boot_idx] : (csr_hit ? host_csr_data : 16'h0000);
            host_irq_level <= level_next;
        end
    end

    // ****************************************
    // dma
    // ****************************************
    // 22-bit dma address
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dma_out <= '0;
        end else begin
            dma_out.req <= dma_start;
            dma_out.wr <= dma_write;
            dma_out.addr <= dma_addr_in;
        end
    end

    // ****************************************
    // drives
    // ****************************************
    // write only to online, unprotected drives
    wire [NUM_DRIVES-1:0] wr_ok = drive_online & ~drive_wprot;
    wire wp_viol = |(drive_wr_req & ~wr_ok);
    wire [NUM_DRIVES-1:0] media_flags = {strap_reg.drive1_removable_flag,
        strap_reg.drive0_removable_flag};
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            drive_wr_gate <= '0;
            drive_removable <= '0;
        end else begin
            drive_wr_gate <= drive_wr_req & wr_ok;
            drive_removable <= media_flags;
        end
    end

    // ****************************************
    // cache
    // ****************************************
    // parity stored beside each byte
    logic [CACHE_DW:0] cache_mem [0:(1<<CAW)-1];
    logic [CACHE_DW:0] cache_word_reg;
    logic cache_rd_reg;
    always_ff @(posedge ref_clk) begin
        if (cache_wr) begin
            cache_mem[cache_addr[CAW-1:0]] <= {^cache_wdata, cache_wdata};
        end
        cache_word_reg <= cache_mem[cache_addr[CAW-1:0]];
    end
    wire parity_bad = cache_rd_reg && (^cache_word_reg != 1'b0);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cache_rd_reg <= 1'b0;
            cache_rdata <= '0;
            cache_parity_err <= 1'b0;
        end else begin
            cache_rd_reg <= cache_rd;
            cache_rdata <= cache_word_reg[CACHE_DW-1:0];
            cache_parity_err <= parity_bad;
        end
    end

    // ****************************************
    // serial receive
    // ****************************************
    logic [15:0] rx_tick_reg;
    logic [3:0] rx_bit_reg;
    logic [CHAR_BITS-1:0] rx_shift_reg;
    logic [CHAR_BITS-1:0] rx_data_reg;
    logic rx_busy_reg;
    logic rx_done;
    wire rx_mid = (rx_tick_reg == 16'(BAUD_CYC / 2));
    wire rx_end = (rx_tick_reg == 16'(BAUD_CYC - 1));
    // receive 7 data bits, one stop, no parity
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_tick_reg <= 16'h0000;
            rx_bit_reg <= 4'h0;
            rx_shift_reg <= '0;
            rx_data_reg <= '0;
            rx_busy_reg <= 1'b0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!rx_busy_reg) begin
                rx_tick_reg <= 16'h0000;
                rx_bit_reg <= 4'h0;
                rx_busy_reg <= !maint_rxd;
            end else begin
                rx_tick_reg <= rx_end ? 16'h0000 : rx_tick_reg + 16'h0001;
                if (rx_mid && rx_bit_reg != 4'h0 && rx_bit_reg <= 4'(CHAR_BITS)) begin
                    rx_shift_reg <= {maint_rxd, rx_shift_reg[CHAR_BITS-1:1]};
                end
                if (rx_mid && rx_bit_reg == 4'(FRAME_BITS - 1)) begin
                    rx_busy_reg <= 1'b0;
                    rx_done <= maint_rxd;
                    rx_data_reg <= rx_shift_reg;
                end
                if (rx_end) begin
                    rx_bit_reg <= rx_bit_reg + 4'h1;
                end
            end
        end
    end

    logic tx_busy;
    wire tx_start = reg_wr && reg_addr == REG_UART_TX && !tx_busy;
    serial_tx7 #(.DIV(BAUD_CYC), .DW(CHAR_BITS)) u_tx (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(tx_start),
        .data(reg_wdata[CHAR_BITS-1:0]),
        .busy(tx_busy),
        .txd(maint_txd)
    );

    // ****************************************
    // registers, events, indicators
    // ****************************************
    logic [NUM_EV-1:0] ev_stat_reg;
    logic [NUM_EV-1:0] ev_mask_reg;
    logic [2:0] ctl_reg;
    wire [NUM_EV-1:0] ev_in;
    assign ev_in[EV_FATAL] = ctl_reg[CTL_FATAL];
    assign ev_in[EV_PARITY] = parity_bad;
    assign ev_in[EV_RX] = rx_done;
    assign ev_in[EV_QFULL] = csr_hit && host_req.wr && q_full;
    assign ev_in[EV_WP_VIOL] = wp_viol;
    wire stat_clr_wr = reg_wr && reg_addr == REG_IRQ_STAT;
    // set wins over a same-cycle clear
    wire [NUM_EV-1:0] ev_stat_next = (ev_stat_reg & ~(stat_clr_wr ? reg_wdata[NUM_EV-1:0] : '0))
        | ev_in;

    wire [31:0] rd_mux =
        (reg_addr == REG_CONFIG) ? 32'({strap_reg, level_next}) :
        (reg_addr == REG_STATUS) ? 32'({pu_reg, drive_online, drive_wprot, tx_busy,
            q_full, q_empty}) :
        (reg_addr == REG_IRQ_STAT) ? 32'(ev_stat_reg) :
        (reg_addr == REG_IRQ_MASK) ? 32'(ev_mask_reg) :
        (reg_addr == REG_CONTROL) ? 32'(ctl_reg) :
        (reg_addr == REG_QUEUE) ? 32'({q_count_reg, q_mem[q_rp_reg]}) :
        (reg_addr == REG_UART_RX) ? 32'(rx_data_reg) : 32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ev_stat_reg <= '0;
            ev_mask_reg <= '0;
            ctl_reg <= '0;
            reg_rdata <= 32'h00000000;
            irq <= 1'b0;
            led_red <= 1'b0;
            led_green <= 1'b0;
            utility_mode <= 1'b0;
        end else begin
            ev_stat_reg <= ev_stat_next;
            if (reg_wr && reg_addr == REG_IRQ_MASK) begin
                ev_mask_reg <= reg_wdata[NUM_EV-1:0];
            end
            if (reg_wr && reg_addr == REG_CONTROL) begin
                ctl_reg <= {1'b0, reg_wdata[CTL_ACTIVE], reg_wdata[CTL_FATAL]};
            end
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
            irq <= |(ev_stat_next & ev_mask_reg);
            // red on fatal or parity failure, green while busy
            led_red <= ctl_reg[CTL_FATAL] | ev_stat_reg[EV_PARITY];
            led_green <= ctl_reg[CTL_ACTIVE] | dma_out.req | host_ack;
            utility_mode <= (pu_reg == PU_UTILITY);
        end
    end
endmodule : disc_controller_strap_config

// ===== strap_cfg_checker.sv
// checker: plug decode, host windows, gating, serial start bit.
// assumes binding into the top module, one clock.
`timescale 1ns/1ps
module strap_cfg_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // plugs and host bus
    input wire strap_cfg_pkg::strap_t straps,
    input wire strap_cfg_pkg::host_req_t host_req,
    input wire logic host_ack,
    input wire logic [2:0] host_irq_level,
    // drives, mode, serial
    input wire logic [1:0] drive_wprot,
    input wire logic [1:0] drive_online,
    input wire logic [1:0] drive_wr_req,
    input wire logic [1:0] drive_wr_gate,
    input wire logic [1:0] drive_removable,
    input wire logic utility_mode,
    input wire logic maint_txd
);
    import strap_cfg_pkg::*;
    strap_t held;
    logic [1:0] cnt;
    wire [21:0] a = host_req.addr;
    wire rd = host_req.rd;
    wire in_hi = a >= BOOT_HIGH_BASE && a < BOOT_HIGH_BASE + BOOT_SPAN;
    wire in_lo = a >= BOOT_LOW_BASE && a < BOOT_LOW_BASE + BOOT_SPAN;
    wire off = held.boot_rom_off_sel;
    wire hi_on = !off && held.boot_rom_high_window_sel;
    wire lo_on = !off && !held.boot_rom_high_window_sel && held.boot_rom_low_window_sel;
    wire [2:0] pri = {held.irq_level_bit2, held.irq_level_bit1, held.irq_level_bit0};
    wire [2:0] lvl = pri == 3'h6 ? 3'h7 : pri == 3'h2 ? 3'h6 : pri == 3'h1 ? 3'h5 : 3'h4;
    wire [1:0] may = drive_wr_req & drive_online & ~drive_wprot;
    // judge only after three settled edges
    wire ok = cnt == 2'h3;
    always_ff @(posedge ref_clk) if (reset) held <= straps;
    always_ff @(posedge ref_clk) if (reset) cnt <= 2'h0; else if (!ok) cnt <= cnt + 2'h1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence start_bit; !maint_txd [*8]; endsequence
    level_map_a: assert property (ok |-> host_irq_level == lvl)
        else $error("bad level");
    media_flag_a: assert property (ok |-> drive_removable ==
        {held.drive1_removable_flag, held.drive0_removable_flag}) else $error("bad media");
    mode_plug_a: assert property (ok |-> utility_mode == held.powerup_utility_sel)
        else $error("bad mode");
    gate_cause_a: assert property (ok |=> drive_wr_gate == $past(may))
        else $error("bad gate");
    start_len_a: assert property ($fell(maint_txd) |-> start_bit)
        else $error("short start");
    boot_off_a: assert property (off && rd && (in_hi || in_lo) |=> !host_ack)
        else $error("boot on");
    boot_high_a: assert property (hi_on && rd && in_hi |=> host_ack)
        else $error("high silent");
    boot_low_a: assert property (lo_on && rd && in_lo |=> host_ack)
        else $error("low silent");
    csr_hit_a: assert property (held.base_sel[0] && host_req.wr && a == BASE_ADDR_0 |=> host_ack)
        else $error("base silent");
endmodule : strap_cfg_checker
bind disc_controller_strap_config strap_cfg_checker i_strap_cfg_checker (.*);

// ===== host_master.sv
// host_master: host issuing one-cycle backplane accesses.
// assumes a one-cycle acknowledge after a hit.
`timescale 1ns/1ps
module host_master (
    // clock
    input wire logic ref_clk,
    // bus
    output strap_cfg_pkg::host_req_t host_req,
    input wire logic host_ack
);
    import strap_cfg_pkg::*;
    initial host_req = '0;
    // idle lines show the inverse so stale values miss
    task automatic access(input logic [21:0] adr, input logic w, output logic ack);
        @(posedge ref_clk);
        host_req <= {adr, ~adr[15:0], w, !w};
        @(posedge ref_clk);
        host_req <= {~adr, adr[15:0], 2'b00};
        #1 ack = host_ack;
    endtask : access
endmodule : host_master

// ===== disc_controller_strap_config_bench.sv
// bench: plugs, windows, queue, irq, lamps, gating, dma, serial.
// assumes the bound checker; host_master plays the host.
`timescale 1ns/1ps
module disc_controller_strap_config_bench;
    import strap_cfg_pkg::*;
    logic ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, dma_start = 0, dma_write = 0;
    logic irq, host_ack, ack, cache_parity_err, led_red, led_green, utility_mode, maint_txd;
    strap_t straps = '0, s;
    logic [7:0] reg_addr = '0, cache_rdata;
    logic [31:0] reg_wdata = '0, reg_rdata, d;
    host_req_t host_req;
    logic [15:0] host_rdata;
    logic [2:0] host_irq_level;
    logic [21:0] dma_addr_in = '0;
    dma_req_t dma_out;
    logic [1:0] drive_wprot = '0, drive_online = '0, drive_wr_req = '0;
    logic [1:0] drive_wr_gate, drive_removable;
    logic [6:0] c;
    logic [8:0] got;
    int fail_count = 0, compares = 0, k, b, n;
    logic [21:0] base_tab [6] = '{BASE_ADDR_0, BASE_ADDR_1, BASE_ADDR_2, BASE_ADDR_3,
        BASE_ADDR_4, BASE_ADDR_5};
    // serial line looped back so the receiver sees every sent frame
    disc_controller_strap_config #(.CAW(8), .BAUD_CYC(16)) i_disc_controller_strap_config (.*,
        .cache_wr(1'b0), .cache_rd(1'b0), .cache_addr(20'h0),
        .cache_wdata(dma_addr_in[7:0]), .maint_rxd(maint_txd));
    host_master i_host_master (.*);
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic reg_w(input logic [7:0] adr, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= adr;
        reg_wdata <= v;
        reg_wr <= 1;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask : reg_w
    task automatic reg_r(input logic [7:0] adr, output logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= adr;
        reg_rd <= 1;
        @(posedge ref_clk);
        reg_rd <= 0;
        #1 v = reg_rdata;
    endtask : reg_r
    task automatic start(input strap_t sv);
        @(posedge ref_clk);
        reset <= 1;
        straps <= sv;
        repeat (8) @(posedge ref_clk);
        reset <= 0;
        straps <= ~sv;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : start
    task automatic complete_run;
        $display("compares=%0d mismatches=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        complete_run;
    end
    initial begin
        void'($urandom(65018));
        for (k = 0; k < 4; k++) begin
            b = $urandom % 6;
            s = strap_t'(15'($urandom));
            s.base_sel = 6'h1 << b;
            {s.boot_rom_off_sel, s.boot_rom_high_window_sel, s.boot_rom_low_window_sel} = 3'h4 >> k;
            {s.irq_level_bit2, s.irq_level_bit1, s.irq_level_bit0} = k == 3 ? 3'h6 : 3'(k);
            start(s);
            chk(host_irq_level, 4 + k);
            chk(drive_removable, {s.drive1_removable_flag, s.drive0_removable_flag});
            chk(utility_mode, s.powerup_utility_sel);
            i_host_master.access(base_tab[b], 1, ack);
            chk(ack, 1);
            i_host_master.access(base_tab[(b + 1) % 6], 1, ack);
            chk(ack, 0);
            i_host_master.access(BOOT_HIGH_BASE + 22'h1FE, 0, ack);
            chk(ack, k == 1);
            i_host_master.access(BOOT_LOW_BASE, 0, ack);
            chk(ack, k == 2);
            $display("plug case %0d done", k);
        end
        for (k = 0; k < 24; k++) begin
            @(posedge ref_clk);
            {drive_wprot, drive_online, drive_wr_req} <= 6'($urandom);
            dma_addr_in <= 22'($urandom);
            {dma_start, dma_write} <= 2'($urandom);
            @(posedge ref_clk);
            #1 chk(drive_wr_gate, drive_wr_req & drive_online & ~drive_wprot);
            if (dma_start) chk(dma_out, {dma_addr_in, dma_write, 1'b1});
        end
        $display("gating and dma done");
        s = '0;
        s.base_sel = 6'h1;
        start(s);
        for (k = 0; k < 32; k++) i_host_master.access(BASE_ADDR_0, 1, ack);
        reg_r(REG_STATUS, d);
        chk(d[1], 1);
        reg_r(REG_IRQ_STAT, d);
        chk(d[EV_QFULL], 0);
        i_host_master.access(BASE_ADDR_0, 1, ack);
        reg_r(REG_IRQ_STAT, d);
        chk(d[EV_QFULL], 1);
        chk(irq, 0);
        reg_w(REG_IRQ_MASK, 32'h8);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq, 1);
        reg_w(REG_IRQ_STAT, 32'h8);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq, 0);
        reg_r(8'hFC, d);
        chk(d, 0);
        $display("queue and interrupt done");
        reg_w(REG_CONTROL, 32'h2);
        repeat (2) @(posedge ref_clk);
        #1 chk({led_red, led_green}, 2'b01);
        reg_w(REG_CONTROL, 32'h3);
        repeat (2) @(posedge ref_clk);
        #1 chk({led_red, led_green}, 2'b11);
        c = 7'($urandom);
        reg_w(REG_UART_TX, {25'h0, c});
        #1;
        for (n = 0; n < 40 && maint_txd; n++) #10;
        chk(n < 40, 1);
        // sample at bit centres
        #79;
        for (k = 0; k < 9; k++) begin
            got = {maint_txd, got[8:1]};
            #160;
        end
        chk(got, {1'b1, c, 1'b0});
        reg_r(REG_UART_RX, d);
        chk(d, {25'h0, c});
        $display("lamps and serial done");
        complete_run;
    end
endmodule : disc_controller_strap_config_bench
